// ==== rtl/dams_regs.svh ====
`ifndef DAMS_REGS_SVH
`define DAMS_REGS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define DAMS_SEL1_OFS   8'h00
`define DAMS_SEL2_OFS   8'h04
`define DAMS_OFF1_OFS   8'h08
`define DAMS_OFF2_OFS   8'h0C
`define DAMS_MUL1_OFS   8'h10
`define DAMS_MUL2_OFS   8'h14
`define DAMS_CODE1_OFS  8'h18
`define DAMS_CODE2_OFS  8'h1C

// ****************************************************************
// Reset values
// ****************************************************************
`define DAMS_SEL1_RST   16'h0002
`define DAMS_SEL2_RST   16'h0000
`define DAMS_OFF_RST    16'h0000
`define DAMS_MUL1_RST   16'h0064
`define DAMS_MUL2_RST   16'h0064

// ****************************************************************
// Field positions and limits
// ****************************************************************
`define DAMS_SEL_LSB    0
`define DAMS_SEL_MSB    7
`define DAMS_SET_MAX    16'sh2710
`define DAMS_SET_MIN    16'shD8F0

// ****************************************************************
// Scaling constants (millivolt domain, code = -V * 4096)
// ****************************************************************
`define DAMS_PERR_MV    24'sh00_0032
`define DAMS_DONE_MV    24'sh00_1388
`define DAMS_GAIN1_MV   24'sh00_03E8
`define DAMS_GAIN2_MV   24'sh00_07D0
`define DAMS_OFF_K      41'sh000_0000_2710
`define DAMS_RECIP      72'sh00_0000_0000_029F_16B1
`define DAMS_ROUND      72'sh00_0000_0000_2000_0000
`define DAMS_SHIFT      30
`define DAMS_CODE_MAX   72'sh00_0000_0000_0000_7FFF
`define DAMS_CODE_MIN   72'shFF_FFFF_FFFF_FFFF_8000

`endif

// ==== rtl/dams_pkg.sv ====
package dams_pkg;

  typedef logic signed [15:0] dams_word_t;

  typedef enum logic [3:0] {
    DAMS_SRC_SPEED   = 4'b0000,
    DAMS_SRC_SPDREF  = 4'b0001,
    DAMS_SRC_FRCREF  = 4'b0010,
    DAMS_SRC_PERR    = 4'b0011,
    DAMS_SRC_PAMP    = 4'b0100,
    DAMS_SRC_PREFSPD = 4'b0101,
    DAMS_SRC_POSDONE = 4'b1000,
    DAMS_SRC_SPDFF   = 4'b1001,
    DAMS_SRC_FRCFF   = 4'b1010,
    DAMS_SRC_GAIN    = 4'b1011,
    DAMS_SRC_REFDONE = 4'b1100
  } dams_src_e;

  typedef struct packed {
    logic [15:0]        sel1;
    logic [15:0]        sel2;
    logic signed [15:0] off1;
    logic signed [15:0] off2;
    logic signed [15:0] mul1;
    logic signed [15:0] mul2;
    logic signed [15:0] code1;
    logic signed [15:0] code2;
    logic               ack;
    logic [31:0]        dat;
  } dams_state_s;

endpackage

// ==== rtl/dams_top.sv ====
// Added by the designer: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
`include "dams_regs.svh"

module dams_top #(
  parameter int AW = 8
) (
  input  wire logic              clk_i,           // System clock
  input  wire logic              rst_i,           // Sync reset, high
  input  wire logic              wb_cyc_i,        // Bus cycle
  input  wire logic              wb_stb_i,        // Bus strobe
  input  wire logic              wb_we_i,         // Write enable
  input  wire logic [AW-1:0]     wb_adr_i,        // Byte address
  input  wire logic [3:0]        wb_sel_i,        // Byte lanes
  input  wire logic [31:0]       wb_dat_i,        // Write data
  output logic      [31:0]       wb_dat_o,        // Read data
  output logic                   wb_ack_o,        // Acknowledge
  input  wire dams_pkg::dams_word_t motor_speed_i,  // mm/s
  input  wire dams_pkg::dams_word_t speed_ref_i,    // mm/s
  input  wire dams_pkg::dams_word_t pos_ref_speed_i, // mm/s
  input  wire dams_pkg::dams_word_t speed_ff_i,     // mm/s
  input  wire dams_pkg::dams_word_t force_ref_i,    // 0.1 % rated
  input  wire dams_pkg::dams_word_t force_ff_i,     // 0.1 % rated
  input  wire dams_pkg::dams_word_t pos_err_i,      // Reference units
  input  wire dams_pkg::dams_word_t pos_amp_err_i,  // Scale pulses
  input  wire logic              pos_ctrl_i,      // Position control
  input  wire logic              pos_done_i,      // Positioning done
  input  wire logic              gain2_i,         // Second gain set
  input  wire logic              ref_done_i,      // Reference done
  output dams_pkg::dams_word_t   mon1_code_o,     // Channel 1 code
  output dams_pkg::dams_word_t   mon2_code_o      // Channel 2 code
);
  import dams_pkg::*;

  dams_state_s        st_r;
  dams_state_s        st_nxt;
  logic [15:0][23:0]  base_tab;
  logic               req;
  logic [7:0]         adr_w;
  logic signed [23:0] base1;
  logic signed [23:0] base2;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [15:0] dams_lane(input logic [15:0] old,
                                            input logic [15:0] wd,
                                            input logic [1:0]  be);
    logic [15:0] v;
    v = old;
    if (be[0]) begin
      v[7:0] = wd[7:0];
    end
    if (be[1]) begin
      v[15:8] = wd[15:8];
    end
    return v;
  endfunction

  // Out-of-range settings are pinned rather than rejected, so a
  // sloppy write still leaves a legal, bounded gain or offset
  function automatic logic signed [15:0] dams_clamp(
      input logic signed [15:0] v);
    logic signed [15:0] r;
    r = v;
    if (v > `DAMS_SET_MAX) begin
      r = `DAMS_SET_MAX;
    end else if (v < `DAMS_SET_MIN) begin
      r = `DAMS_SET_MIN;
    end
    return r;
  endfunction

  // Numerator is in units of 0.01 mV; the constant divide by 100000
  // is a reciprocal multiply with rounding, no divider in the path
  function automatic logic signed [15:0] dams_scale(
      input logic signed [23:0] base,
      input logic signed [15:0] mul,
      input logic signed [15:0] off);
    logic signed [40:0] num;
    logic signed [71:0] prod;
    logic signed [71:0] q;
    logic signed [15:0] r;
    num  = 41'(base) * 41'(mul) + 41'(off) * `DAMS_OFF_K;
    prod = 72'(num) * `DAMS_RECIP + `DAMS_ROUND;
    q    = -(prod >>> `DAMS_SHIFT);
    if (q > `DAMS_CODE_MAX) begin
      r = 16'sh7FFF;
    end else if (q < `DAMS_CODE_MIN) begin
      r = 16'sh8000;
    end else begin
      r = q[15:0];
    end
    return r;
  endfunction

  // ****************************************************************
  // Source values in millivolts before gain and offset
  // ****************************************************************
  always_comb begin
    base_tab = '0;
    base_tab[DAMS_SRC_SPEED]    = 24'(motor_speed_i);
    base_tab[DAMS_SRC_SPDREF]   = 24'(speed_ref_i);
    base_tab[DAMS_SRC_PREFSPD]  = 24'(pos_ref_speed_i);
    base_tab[DAMS_SRC_SPDFF]    = 24'(speed_ff_i);
    base_tab[DAMS_SRC_FRCREF]   = 24'(force_ref_i);
    base_tab[DAMS_SRC_FRCFF]    = 24'(force_ff_i);
    if (pos_ctrl_i) begin
      base_tab[DAMS_SRC_PERR] = 24'(24'(pos_err_i) * `DAMS_PERR_MV);
    end
    base_tab[DAMS_SRC_PAMP] = 24'(24'(pos_amp_err_i) * `DAMS_PERR_MV);
    base_tab[DAMS_SRC_POSDONE] = pos_done_i ? `DAMS_DONE_MV
                                            : 24'sh00_0000;
    base_tab[DAMS_SRC_GAIN] = gain2_i ? `DAMS_GAIN2_MV
                                      : `DAMS_GAIN1_MV;
    base_tab[DAMS_SRC_REFDONE] = ref_done_i ? `DAMS_DONE_MV
                                            : 24'sh00_0000;
  end

  // Codes 0x10-0xFF in bits 7:0 select nothing, bits 15:8 are ignored; reserved slots stay zero above
  always_comb begin
    base1 = 24'sh00_0000;
    base2 = 24'sh00_0000;
    if (st_r.sel1[7:4] == 4'h0) begin
      base1 = $signed(base_tab[st_r.sel1[3:0]]);
    end
    if (st_r.sel2[7:4] == 4'h0) begin
      base2 = $signed(base_tab[st_r.sel2[3:0]]);
    end
  end

  // ****************************************************************
  // Bus slave and next state
  // ****************************************************************
  assign req   = wb_cyc_i & wb_stb_i & ~st_r.ack;
  assign adr_w = 8'({wb_adr_i[AW-1:2], 2'b00});

  always_comb begin
    st_nxt     = st_r;
    st_nxt.ack = req;
    st_nxt.dat = '0;
    if (req && !wb_we_i) begin
      unique case (adr_w)
        `DAMS_SEL1_OFS:  st_nxt.dat = {16'h0000, st_r.sel1};
        `DAMS_SEL2_OFS:  st_nxt.dat = {16'h0000, st_r.sel2};
        `DAMS_OFF1_OFS:  st_nxt.dat = {16'h0000, st_r.off1};
        `DAMS_OFF2_OFS:  st_nxt.dat = {16'h0000, st_r.off2};
        `DAMS_MUL1_OFS:  st_nxt.dat = {16'h0000, st_r.mul1};
        `DAMS_MUL2_OFS:  st_nxt.dat = {16'h0000, st_r.mul2};
        `DAMS_CODE1_OFS: st_nxt.dat = {16'h0000, st_r.code1};
        `DAMS_CODE2_OFS: st_nxt.dat = {16'h0000, st_r.code2};
        default:         st_nxt.dat = '0;
      endcase
    end
    if (req && wb_we_i) begin
      unique case (adr_w)
        `DAMS_SEL1_OFS: begin
          st_nxt.sel1 = dams_lane(st_r.sel1, wb_dat_i[15:0],
                                  wb_sel_i[1:0]);
        end
        `DAMS_SEL2_OFS: begin
          st_nxt.sel2 = dams_lane(st_r.sel2, wb_dat_i[15:0],
                                  wb_sel_i[1:0]);
        end
        `DAMS_OFF1_OFS: begin
          st_nxt.off1 = dams_clamp(dams_lane(st_r.off1, wb_dat_i[15:0],
                                             wb_sel_i[1:0]));
        end
        `DAMS_OFF2_OFS: begin
          st_nxt.off2 = dams_clamp(dams_lane(st_r.off2, wb_dat_i[15:0],
                                             wb_sel_i[1:0]));
        end
        `DAMS_MUL1_OFS: begin
          st_nxt.mul1 = dams_clamp(dams_lane(st_r.mul1, wb_dat_i[15:0],
                                             wb_sel_i[1:0]));
        end
        `DAMS_MUL2_OFS: begin
          st_nxt.mul2 = dams_clamp(dams_lane(st_r.mul2, wb_dat_i[15:0],
                                             wb_sel_i[1:0]));
        end
        default: begin
        end
      endcase
    end
    // Settings act on the very next code, with no staging register
    st_nxt.code1 = dams_scale(base1, st_r.mul1, st_r.off1);
    st_nxt.code2 = dams_scale(base2, st_r.mul2, st_r.off2);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r       <= '0;
      st_r.sel1  <= `DAMS_SEL1_RST;
      st_r.sel2  <= `DAMS_SEL2_RST;
      st_r.off1  <= `DAMS_OFF_RST;
      st_r.off2  <= `DAMS_OFF_RST;
      st_r.mul1  <= `DAMS_MUL1_RST;
      st_r.mul2  <= `DAMS_MUL2_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack_o    = st_r.ack;
  assign wb_dat_o    = st_r.dat;
  assign mon1_code_o = st_r.code1;
  assign mon2_code_o = st_r.code2;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking dams_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  reset_select_a: assert property ($past(rst_i) |->
      (st_r.sel1 == 16'h0002 && st_r.sel2 == 16'h0000 &&
       st_r.mul1 == 16'sh0064))
    else $error("select or multiplier wrong after reset");

  speed_scale_a: assert property ((st_r.sel2[7:0] == 8'h00 &&
      st_r.mul2 == 16'sh0064 && st_r.off2 == 16'sh0000 &&
      motor_speed_i == 16'sh03E8) |=> mon2_code_o == 16'shF000)
    else $error("speed channel not 1 V per 1000 mm/s");

  force_scale_a: assert property ((st_r.sel1[7:0] == 8'h02 &&
      st_r.mul1 == 16'sh0064 && st_r.off1 == 16'sh0000 &&
      force_ref_i == 16'sh03E8) |=> mon1_code_o == 16'shF000)
    else $error("force channel not 1 V per rated force");

  perr_zero_a: assert property ((st_r.sel1[7:0] == 8'h03 &&
      !pos_ctrl_i && st_r.off1 == 16'sh0000)
      |=> mon1_code_o == 16'sh0000)
    else $error("position error not zero outside position control");

  pamp_scale_a: assert property ((st_r.sel1[7:0] == 8'h04 &&
      st_r.mul1 == 16'sh0064 && st_r.off1 == 16'sh0000 &&
      pos_amp_err_i == 16'sh0014) |=> mon1_code_o == 16'shF000)
    else $error("amplifier error not 0.05 V per pulse");

  done_level_a: assert property ((st_r.sel1[7:0] == 8'h08 &&
      st_r.mul1 == 16'sh0064 && st_r.off1 == 16'sh0000)
      |=> mon1_code_o == ($past(pos_done_i) ? 16'shB000
                                            : 16'sh0000))
    else $error("positioning completed level wrong");

  gain_level_a: assert property ((st_r.sel2[7:0] == 8'h0B &&
      st_r.mul2 == 16'sh0064 && st_r.off2 == 16'sh0000)
      |=> mon2_code_o == ($past(gain2_i) ? 16'shE000
                                         : 16'shF000))
    else $error("active gain level wrong");

  refdone_level_a: assert property ((st_r.sel2[7:0] == 8'h0C &&
      st_r.mul2 == 16'sh0064 && st_r.off2 == 16'sh0000 && ref_done_i)
      |=> mon2_code_o == 16'shB000)
    else $error("reference completion level wrong");

  offset_sign_a: assert property ((st_r.sel1[7:0] == 8'h06 &&
      st_r.off1 == 16'sh000A) |=> mon1_code_o == 16'shF000)
    else $error("offset sign or reserved zero wrong");

  sat_limit_a: assert property ((st_r.sel2[7:0] == 8'h0D &&
      st_r.off2 == 16'sh2710) |=> mon2_code_o == 16'sh8000)
    else $error("output code not saturated");

  off_clamp_a: assert property ((req && wb_we_i &&
      adr_w == `DAMS_OFF1_OFS && wb_sel_i[1:0] == 2'b11 &&
      wb_dat_i[15:0] == 16'h4E20) |=> st_r.off1 == 16'sh2710)
    else $error("offset write not clamped");

  ack_pulse_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o)
      |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus acknowledge not a single cycle");

  wr_cov_c:  cover property (req && wb_we_i);
  sat_cov_c: cover property (mon1_code_o == 16'sh7FFF);
  rsv_cov_c: cover property (st_r.sel1[7:0] == 8'h07);
  mix_cov_c: cover property (st_r.sel1 != st_r.sel2 &&
                             mon1_code_o != mon2_code_o);

endmodule

// ==== tb/dams_recorder.sv ====
`timescale 1ns/10ps
// ****************************************************************
// Measuring instrument on one monitor output
// ****************************************************************
module dams_recorder (
  input  wire logic                 clk_i,  // Sample clock
  input  wire logic                 rst_i,  // Clears the trace
  input  wire dams_pkg::dams_word_t code_i, // Converter code
  output logic signed [31:0]        mv_o    // Last sample in mV
);
  import dams_pkg::*;

  // Passive probe: it never drives the block, so it cannot hide a fault
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mv_o <= 32'sh0000_0000;
    end else begin
      mv_o <= (32'(code_i) * 32'sh0000_03E8) >>> 12;
    end
  end
endmodule

// ==== tb/dual_analog_monitor_select_scale_bench.sv ====
`timescale 1ns/10ps
`include "dams_regs.svh"
module dual_analog_monitor_select_scale_bench;
  import dams_pkg::*;
  typedef struct {logic [1:0] k; logic [31:0] e;} dams_note_s;
  logic        clk_i = 1'b0;
  logic        rst_i;
  logic        cyc, stb, we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, rdat;
  logic        ack;
  dams_word_t  src [8];
  dams_word_t  mon1, mon2;
  logic        pos_ctrl, pos_done, gain2, ref_done;
  logic signed [31:0] mv1, mv2;
  logic [31:0] rng;
  logic [15:0] sh [6];
  logic [7:0]  ofs [6];
  dams_note_s  q [$];
  int          fails = 0;
  int          tests_run = 0;

  always #2.5 clk_i = ~clk_i;

  dams_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .motor_speed_i(src[0]), .speed_ref_i(src[1]),
    .pos_ref_speed_i(src[2]), .speed_ff_i(src[3]),
    .force_ref_i(src[4]), .force_ff_i(src[5]), .pos_err_i(src[6]),
    .pos_amp_err_i(src[7]), .pos_ctrl_i(pos_ctrl),
    .pos_done_i(pos_done), .gain2_i(gain2), .ref_done_i(ref_done),
    .mon1_code_o(mon1), .mon2_code_o(mon2));
  dams_recorder rec1 (.clk_i(clk_i), .rst_i(rst_i), .code_i(mon1),
    .mv_o(mv1));
  dams_recorder rec2 (.clk_i(clk_i), .rst_i(rst_i), .code_i(mon2),
    .mv_o(mv2));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] next_rand();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  function automatic logic [15:0] rset(int lim);
    return 16'(int'(next_rand() % (2 * lim + 1)) - lim);
  endfunction

  // Shadow layout: 0/1 select, 2/3 offset, 4/5 multiplier
  function automatic logic [31:0] exp_code(int ch);
    longint b;
    longint x;
    longint m;
    case (sh[ch][7:0])
      8'h00: b = src[0];
      8'h01: b = src[1];
      8'h02: b = src[4];
      8'h03: b = pos_ctrl ? 16'sh0032 * src[6] : 16'sh0000;
      8'h04: b = 16'sh0032 * src[7];
      8'h05: b = src[2];
      8'h08: b = pos_done ? 16'sh1388 : 16'sh0000;
      8'h09: b = src[3];
      8'h0A: b = src[5];
      8'h0B: b = gain2 ? 16'sh07D0 : 16'sh03E8;
      8'h0C: b = ref_done ? 16'sh1388 : 16'sh0000;
      default: b = 0;
    endcase
    x = b * $signed(sh[4 + ch]) + $signed(sh[2 + ch]) * 16'sh2710;
    m = (x < 0) ? -x : x;
    m = (m * 64'sh0000_0000_029F_16B1 + 64'sh0000_0000_2000_0000) >>> 30;
    if (x > 0) m = -m;
    if (m > 16'sh7FFF) m = 16'sh7FFF;
    if (m < 16'sh8000) m = 16'sh8000;
    return {16'h0000, m[15:0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      fails++;
      print_verdict();
    end
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back('{2'd2, e});
    wb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic note_mon();
    q.push_back('{2'd0, exp_code(0)});
    q.push_back('{2'd1, exp_code(1)});
  endtask

  // Writes one setting and keeps the shadow copy in step with it
  task automatic put(input int i, input logic [15:0] v);
    sh[i] = v;
    wb(1'b1, ofs[i], {16'h0000, v});
  endtask

  task automatic step();
    repeat (2) @(posedge clk_i);
    note_mon();
  endtask

  // ****************************************************************
  // Result watcher
  // ****************************************************************
  always @(negedge clk_i) begin
    dams_note_s n;
    if (q.size() > 0 && q[0].k == 2'd2 && ack === 1'b1) begin
      n = q.pop_front();
      check(rdat, n.e);
    end
    while (q.size() > 0 && q[0].k != 2'd2) begin
      n = q.pop_front();
      check({16'h0000, (n.k == 2'd0) ? mon1 : mon2}, n.e);
    end
  end

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, sel, adr, dat} = '0;
    rng = 32'h0000_0059;
    foreach (src[i]) src[i] = rset(1000);
    {pos_ctrl, pos_done, gain2, ref_done} = 4'h0;
    ofs = '{`DAMS_SEL1_OFS, `DAMS_SEL2_OFS, `DAMS_OFF1_OFS,
            `DAMS_OFF2_OFS, `DAMS_MUL1_OFS, `DAMS_MUL2_OFS};
    sh = '{16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h0064};
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    note_mon();
    for (int i = 0; i < 6; i++) reg_rd(ofs[i], {16'h0000, sh[i]});
    reg_rd(8'h20, 32'h0000_0000);
    $display("reset test done");
    // Pass 0 keeps sources within 60 and settings within 150, pass 1 drives the output into saturation
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 14; c++) begin
        @(posedge clk_i);
        foreach (src[i]) src[i] <= rset(p ? 32767 : 60);
        pos_ctrl <= (p == 0);
        {pos_done, gain2, ref_done} <= next_rand() % 8;
        sh[0] = 16'(c);
        sh[1] = 16'(13 - c);
        for (int i = 2; i < 6; i++) sh[i] = rset(p ? 10000 : 150);
        for (int i = 0; i < 6; i++) wb(1'b1, ofs[i], {16'h0000, sh[i]});
        repeat (2) @(posedge clk_i);
        note_mon();
        reg_rd(`DAMS_SEL1_OFS, 32'(c));
      end
    end
    $display("source sweep test done");
    wb(1'b1, `DAMS_MUL1_OFS, 32'h0000_4E20);
    reg_rd(`DAMS_MUL1_OFS, 32'h0000_2710);
    wb(1'b1, `DAMS_OFF2_OFS, 32'h0000_B1E0);
    reg_rd(`DAMS_OFF2_OFS, 32'h0000_D8F0);
    $display("clamp test done");
    // Exact unit inputs so the scale assertions see their trigger
    @(posedge clk_i);
    src[0] <= 16'sh03E8;
    src[4] <= 16'sh03E8;
    src[7] <= 16'sh0014;
    {pos_done, gain2, ref_done} <= 3'b111;
    put(0, 16'h0002);
    put(1, 16'h0000);
    put(2, 16'h0000);
    put(3, 16'h0000);
    put(4, 16'h0064);
    put(5, 16'h0064);
    step();
    put(0, 16'h0004);
    step();
    put(0, 16'h0003);
    step();
    put(0, 16'h0008);
    put(1, 16'h000B);
    step();
    put(1, 16'h000C);
    step();
    put(0, 16'h0006);
    put(2, 16'h000A);
    put(1, 16'h000D);
    put(3, 16'h2710);
    step();
    $display("unit scale test done");
    repeat (4) @(posedge clk_i);
    print_verdict();
  end
endmodule
